// ---- rtl/pwmsd_pkg.sv ----
// package for the pwm shutdown and clock generation front end
// assumes one 25 MHz bus clock and a byte-wide register port
package pwmsd_pkg;

    // register port shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_CH = 6;

    // register offsets (byte addresses)
    localparam logic [7:0] OFF_SDN = 8'h00;
    localparam logic [7:0] OFF_CTL = 8'h04;
    localparam logic [7:0] OFF_PRCLK = 8'h08;
    localparam logic [7:0] OFF_SCLA = 8'h0C;
    localparam logic [7:0] OFF_SCLB = 8'h10;
    localparam logic [7:0] OFF_CLKSEL = 8'h14;
    localparam logic [7:0] OFF_CHEN = 8'h18;

    // shutdown control field positions
    localparam int SDN_FLAG_BIT = 7;
    localparam int SDN_IE_BIT = 6;
    localparam int SDN_RSTRT_BIT = 5;
    localparam int SDN_LVL_BIT = 4;
    localparam int SDN_PIN_BIT = 2;
    localparam int SDN_INL_BIT = 1;
    localparam int SDN_ENA_BIT = 0;

    // unit control field positions
    localparam int CTL_FRZ_BIT = 2;

    // prescale select fields
    localparam int PRCLK_A_LSB = 0;
    localparam int PRCLK_B_LSB = 4;
    localparam int PRESCALE_W = 7;

    // values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] SCALE_ONE = 8'h01;

    // software-held shutdown settings
    typedef struct packed {
        logic irq_en;
        logic out_level;
        logic active_high;
        logic enable;
    } pwmsd_sdn_t;

    localparam pwmsd_sdn_t SDN_RST = '{irq_en: 1'b0, out_level: 1'b0, active_high: 1'b0, enable: 1'b0};

endpackage : pwmsd_pkg

// ---- rtl/pwmsd_top.sv ----
// shutdown and clock generation front end of a six-channel 8-bit pwm unit
// assumes channel counters, waveforms and the pad live outside; pin input is synchronous
//
// Operation
// R1: fault input change either way sets the change flag; write 1 clears, 0 leaves.
// R2: interrupt request follows change flag only while interrupt enable is 1.
// R3: restart accepted only with fault deasserted; channels resume at next counter zero.
// R4: restart request bit always reads back as 0.
// R5: clearing shutdown enable resumes channels only after their counters pass zero.
// R6: active fault drives every enabled channel output to the shutdown level bit.
// R7: status bit returns present level of the channel 5 fault pin.
// R8: active-level bit selects low (0) or high (1) as the fault level.
// R9: shutdown enable makes channel 5 an input; other bits matter only then.
// R10: clocks a and b divide bus clock by 1 to 128 via 3-bit fields.
// R11: freeze-stop bit with processor frozen gates off prescaler clock.
// R12: prescaler clock gated off while all six channel enables are 0.
// R13: 8-bit scale down counter reloads and pulses at 1, then divide by two.
// R14: scale value zero counts as 256, giving division by 512.
// R15: writing a scale value reloads its down counter at once.
// R16: channels 0,1,4,5 pick a or sa; channels 2,3 pick b or sb.
// R17: software avoids changing clock selects or scales while channels run.
// R18: channel counters return to zero each period; pending restart acts there.
// R19: prescale code n divides bus clock by 2 to the power n.
// R20: select 0 picks prescaled, 1 scaled; forced levels hold until restart completes.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module pwmsd_top (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // register port
    input wire logic [pwmsd_pkg::ADDR_W-1:0] i_addr,
    input wire logic [pwmsd_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [pwmsd_pkg::DATA_W-1:0] o_rdata,
    // system
    input wire logic i_freeze,
    output logic o_irq,
    // channel logic side
    input wire logic [pwmsd_pkg::NUM_CH-1:0] i_ch_wave,
    input wire logic [pwmsd_pkg::NUM_CH-1:0] i_cnt_zero,
    output logic [pwmsd_pkg::NUM_CH-1:0] o_ch_out,
    output logic [pwmsd_pkg::NUM_CH-1:0] o_ch_clk_en,
    output logic [pwmsd_pkg::NUM_CH-1:0] o_ch_enable,
    // clock enables
    output logic o_clk_a_en,
    output logic o_clk_b_en,
    output logic o_clk_sa_en,
    output logic o_clk_sb_en,
    // fault pin
    input wire logic i_fault_pin,
    output logic o_ch5_pin_oe
);

    localparam int CH5 = 5;

    pwmsd_pkg::pwmsd_sdn_t sdn_r;
    logic flag_r;
    logic frz_r;
    logic [2:0] div_a_r;
    logic [2:0] div_b_r;
    logic [7:0] scale_r [0:1];
    logic [pwmsd_pkg::NUM_CH-1:0] clk_sel_r;
    logic [pwmsd_pkg::NUM_CH-1:0] ch_en_r;
    logic active_r;
    logic restart_pend_r;
    logic lvl_hold_r;
    logic [pwmsd_pkg::NUM_CH-1:0] shut_r;
    logic [pwmsd_pkg::NUM_CH-1:0] out_r;
    logic [pwmsd_pkg::PRESCALE_W-1:0] pre_cnt_r;
    logic [7:0] scl_cnt_r [0:1];
    logic [1:0] half_r;
    logic [pwmsd_pkg::DATA_W-1:0] rdata_r;

    logic wr_sdn;
    logic wr_ctl;
    logic wr_prclk;
    logic wr_clksel;
    logic wr_chen;
    logic fault_chg;
    logic ch_any;
    logic frz_stop;
    logic fault_now;
    logic pre_gate;
    logic [1:0] p_en;
    logic [1:0] s_en;
    logic [1:0] scl_wr;
    logic [2:0] div_sel [0:1];
    logic restart_req;
    logic [pwmsd_pkg::DATA_W-1:0] rd_nxt;

    assign wr_sdn = i_wr && (i_addr == pwmsd_pkg::OFF_SDN);
    assign wr_ctl = i_wr && (i_addr == pwmsd_pkg::OFF_CTL);
    assign wr_prclk = i_wr && (i_addr == pwmsd_pkg::OFF_PRCLK);
    assign wr_clksel = i_wr && (i_addr == pwmsd_pkg::OFF_CLKSEL);
    assign wr_chen = i_wr && (i_addr == pwmsd_pkg::OFF_CHEN);

    // fault is only meaningful with the feature on
    assign fault_now = sdn_r.enable && (i_fault_pin == sdn_r.active_high); // [R8] [R9]

    // shutdown settings; flag and restart bits are handled in their own blocks
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sdn_r <= pwmsd_pkg::SDN_RST;
        end else if (wr_sdn) begin
            sdn_r.irq_en <= i_wdata[pwmsd_pkg::SDN_IE_BIT];
            sdn_r.out_level <= i_wdata[pwmsd_pkg::SDN_LVL_BIT];
            sdn_r.active_high <= i_wdata[pwmsd_pkg::SDN_INL_BIT];
            sdn_r.enable <= i_wdata[pwmsd_pkg::SDN_ENA_BIT];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            frz_r <= 1'b0;
        end else if (wr_ctl) begin
            frz_r <= i_wdata[pwmsd_pkg::CTL_FRZ_BIT];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            div_a_r <= 3'h0;
            div_b_r <= 3'h0;
        end else if (wr_prclk) begin
            div_a_r <= i_wdata[pwmsd_pkg::PRCLK_A_LSB +: 3];
            div_b_r <= i_wdata[pwmsd_pkg::PRCLK_B_LSB +: 3];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            clk_sel_r <= '0;
        end else if (wr_clksel) begin
            clk_sel_r <= i_wdata[pwmsd_pkg::NUM_CH-1:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ch_en_r <= '0;
        end else if (wr_chen) begin
            ch_en_r <= i_wdata[pwmsd_pkg::NUM_CH-1:0];
        end
    end

    // scale values are stored apart so their write strobe can reload the counters
    assign scl_wr[0] = i_wr && (i_addr == pwmsd_pkg::OFF_SCLA);
    assign scl_wr[1] = i_wr && (i_addr == pwmsd_pkg::OFF_SCLB);

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            scale_r[0] <= pwmsd_pkg::RST_BYTE;
            scale_r[1] <= pwmsd_pkg::RST_BYTE;
        end else begin
            if (scl_wr[0]) begin
                scale_r[0] <= i_wdata;
            end
            if (scl_wr[1]) begin
                scale_r[1] <= i_wdata;
            end
        end
    end

    assign fault_chg = (fault_now != active_r); // [R1]

    // change flag: a new change in the clearing cycle keeps the flag set
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            active_r <= 1'b0;
            flag_r <= 1'b0;
        end else begin
            active_r <= fault_now;
            if (fault_chg) begin
                flag_r <= 1'b1; // [R1]
            end else if (wr_sdn && i_wdata[pwmsd_pkg::SDN_FLAG_BIT]) begin
                flag_r <= 1'b0; // [R1]
            end
        end
    end

    assign o_irq = flag_r && sdn_r.irq_en && sdn_r.enable; // [R2] [R9]

    // restart is a trigger only; refused while the fault still stands
    assign restart_req = wr_sdn && i_wdata[pwmsd_pkg::SDN_RSTRT_BIT] && sdn_r.enable && !fault_now; // [R3]

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            restart_pend_r <= 1'b0;
        end else if (fault_now) begin
            restart_pend_r <= 1'b0;
        end else if (restart_req) begin
            restart_pend_r <= 1'b1; // [R3]
        end else if (shut_r == '0) begin
            restart_pend_r <= 1'b0;
        end
    end

    // level kept so a later write or disable cannot change a standing shutdown
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            lvl_hold_r <= 1'b0;
        end else if (fault_now) begin
            lvl_hold_r <= sdn_r.out_level; // [R20]
        end
    end

    // per-channel shutdown hold and output stage
    genvar gi;
    generate
        for (gi = 0; gi < pwmsd_pkg::NUM_CH; gi++) begin : g_ch
            always_ff @(posedge i_sys_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    shut_r[gi] <= 1'b0;
                end else if (fault_now && ch_en_r[gi]) begin
                    shut_r[gi] <= 1'b1; // [R6]
                end else if (i_cnt_zero[gi] && (restart_pend_r || !sdn_r.enable)) begin
                    shut_r[gi] <= 1'b0; // [R3] [R5] [R18] [R20]
                end
            end

            // the fault is looked at directly so the forced level lands on the very next edge
            always_ff @(posedge i_sys_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    out_r[gi] <= 1'b0;
                end else if (ch_en_r[gi] && (fault_now || shut_r[gi])) begin
                    out_r[gi] <= fault_now ? sdn_r.out_level : lvl_hold_r; // [R6] [R20]
                end else begin
                    out_r[gi] <= i_ch_wave[gi];
                end
            end

            // group b feeds channels 2 and 3, group a the rest
            if (gi == 2 || gi == 3) begin : g_grp_b
                assign o_ch_clk_en[gi] = clk_sel_r[gi] ? s_en[1] : p_en[1]; // [R16] [R20]
            end else begin : g_grp_a
                assign o_ch_clk_en[gi] = clk_sel_r[gi] ? s_en[0] : p_en[0]; // [R16] [R20]
            end
        end
    endgenerate

    assign o_ch_out = out_r;
    assign o_ch_enable = ch_en_r;

    // channel 5 pin becomes an input while shutdown is enabled
    assign o_ch5_pin_oe = ch_en_r[CH5] && !sdn_r.enable; // [R9]

    // prescaler runs only while something can use it
    assign ch_any = (ch_en_r != '0); // [R12]
    assign frz_stop = frz_r && i_freeze; // [R11]
    assign pre_gate = ch_any && !frz_stop; // [R11] [R12]

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pre_cnt_r <= '0;
        end else if (pre_gate) begin
            pre_cnt_r <= pre_cnt_r + 1'b1;
        end
    end

    assign div_sel[0] = div_a_r;
    assign div_sel[1] = div_b_r;

    // scaled clocks; a reload on write avoids waiting out a stale count
    genvar gk;
    generate
        for (gk = 0; gk < 2; gk++) begin : g_scale
            logic [7:0] mask_w;
            logic [pwmsd_pkg::PRESCALE_W-1:0] mask;
            assign mask_w = 8'((9'h001 << div_sel[gk]) - 9'h001);
            assign mask = mask_w[pwmsd_pkg::PRESCALE_W-1:0];
            // code n ticks once every 2^n gated bus cycles
            assign p_en[gk] = pre_gate && ((pre_cnt_r & mask) == mask); // [R10] [R19]

            always_ff @(posedge i_sys_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    scl_cnt_r[gk] <= pwmsd_pkg::SCALE_ONE;
                    half_r[gk] <= 1'b0;
                end else if (scl_wr[gk]) begin
                    scl_cnt_r[gk] <= i_wdata; // [R15]
                end else if (p_en[gk]) begin
                    if (scl_cnt_r[gk] == pwmsd_pkg::SCALE_ONE) begin
                        scl_cnt_r[gk] <= scale_r[gk]; // [R13]
                        half_r[gk] <= ~half_r[gk];
                    end else begin
                        // zero wraps through 255 and so counts as 256
                        scl_cnt_r[gk] <= scl_cnt_r[gk] - 8'h01; // [R14]
                    end
                end
            end

            // every second reload pulse is one scaled tick
            assign s_en[gk] = p_en[gk] && (scl_cnt_r[gk] == pwmsd_pkg::SCALE_ONE) && half_r[gk]; // [R13]
        end
    endgenerate

    assign o_clk_a_en = p_en[0];
    assign o_clk_b_en = p_en[1];
    assign o_clk_sa_en = s_en[0];
    assign o_clk_sb_en = s_en[1];

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_nxt = '0;
        if (i_addr == pwmsd_pkg::OFF_SDN) begin
            rd_nxt[pwmsd_pkg::SDN_FLAG_BIT] = flag_r;
            rd_nxt[pwmsd_pkg::SDN_IE_BIT] = sdn_r.irq_en;
            rd_nxt[pwmsd_pkg::SDN_RSTRT_BIT] = 1'b0; // [R4]
            rd_nxt[pwmsd_pkg::SDN_LVL_BIT] = sdn_r.out_level;
            rd_nxt[pwmsd_pkg::SDN_PIN_BIT] = i_fault_pin; // [R7]
            rd_nxt[pwmsd_pkg::SDN_INL_BIT] = sdn_r.active_high;
            rd_nxt[pwmsd_pkg::SDN_ENA_BIT] = sdn_r.enable;
        end else if (i_addr == pwmsd_pkg::OFF_CTL) begin
            rd_nxt[pwmsd_pkg::CTL_FRZ_BIT] = frz_r;
        end else if (i_addr == pwmsd_pkg::OFF_PRCLK) begin
            rd_nxt[pwmsd_pkg::PRCLK_A_LSB +: 3] = div_a_r;
            rd_nxt[pwmsd_pkg::PRCLK_B_LSB +: 3] = div_b_r;
        end else if (i_addr == pwmsd_pkg::OFF_SCLA) begin
            rd_nxt = scale_r[0];
        end else if (i_addr == pwmsd_pkg::OFF_SCLB) begin
            rd_nxt = scale_r[1];
        end else if (i_addr == pwmsd_pkg::OFF_CLKSEL) begin
            rd_nxt[pwmsd_pkg::NUM_CH-1:0] = clk_sel_r;
        end else if (i_addr == pwmsd_pkg::OFF_CHEN) begin
            rd_nxt[pwmsd_pkg::NUM_CH-1:0] = ch_en_r;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_r <= '0;
        end else if (i_rd) begin
            rdata_r <= rd_nxt;
        end else begin
            rdata_r <= '0;
        end
    end

    assign o_rdata = rdata_r;

endmodule : pwmsd_top

`default_nettype wire

// ---- testbench/pwmsd_fault_src.sv ----
// fault source model on the channel 5 pin
// assumes the bench commands the level it wants the fault line to show
`timescale 1ns/10ps
`default_nettype none
module pwmsd_fault_src (
    // command
    input wire logic i_level,
    // pin
    input wire logic i_oe,
    input wire logic i_dout,
    output logic o_pin
);
    // the pin is an input only while the device lets go of it
    assign o_pin = i_oe ? i_dout : i_level;
endmodule : pwmsd_fault_src
`default_nettype wire

// ---- testbench/pwmsd_monitor.sv ----
// port checker for the pwm shutdown and clock front end
// assumes it is bound into pwmsd_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module pwmsd_monitor (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // register port
    input wire logic [pwmsd_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [pwmsd_pkg::DATA_W-1:0] o_rdata,
    // outputs and the fault pin
    input wire logic o_irq,
    input wire logic [pwmsd_pkg::NUM_CH-1:0] o_ch_clk_en,
    input wire logic [pwmsd_pkg::NUM_CH-1:0] o_ch_enable,
    input wire logic o_clk_a_en,
    input wire logic o_clk_b_en,
    input wire logic o_clk_sa_en,
    input wire logic o_clk_sb_en,
    input wire logic i_fault_pin,
    input wire logic o_ch5_pin_oe
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    sequence sdn_rd;
        i_rd && i_addr == pwmsd_pkg::OFF_SDN;
    endsequence
    restart_reads_zero_a: assert property (sdn_rd |=> !o_rdata[5]) else $error("restart bit read high");
    pin_status_a: assert property (sdn_rd |=> o_rdata[2] == $past(i_fault_pin)) else $error("pin status");
    pin_input_a: assert property (sdn_rd ##1 o_rdata[0] |-> !o_ch5_pin_oe) else $error("pin driven");
    gate_idle_a: assert property (o_ch_enable == 6'h00 |-> !(o_clk_a_en || o_clk_b_en)) else $error("gate");
    sa_on_a_a: assert property (o_clk_sa_en |-> o_clk_a_en) else $error("sa off a tick");
    sb_on_b_a: assert property (o_clk_sb_en |-> o_clk_b_en) else $error("sb off b tick");
    sel_a_a: assert property (|(o_ch_clk_en & 6'h33) |-> o_clk_a_en || o_clk_sa_en) else $error("sel a");
    sel_b_a: assert property (|(o_ch_clk_en & 6'h0c) |-> o_clk_b_en || o_clk_sb_en) else $error("sel b");
    // the flag only clears by a write, so the request must stand until one
    irq_hold_a: assert property (o_irq && !(i_wr && i_addr == pwmsd_pkg::OFF_SDN) |=> o_irq) else $error("irq");
endmodule : pwmsd_monitor
bind pwmsd_top pwmsd_monitor u_mon (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_ch_clk_en(o_ch_clk_en), .o_ch_enable(o_ch_enable),
    .o_clk_a_en(o_clk_a_en), .o_clk_b_en(o_clk_b_en), .o_clk_sa_en(o_clk_sa_en), .o_clk_sb_en(o_clk_sb_en),
    .i_fault_pin(i_fault_pin), .o_ch5_pin_oe(o_ch5_pin_oe));
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the pwm shutdown and clock front end
// assumes the fault source model and the bound port checker
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, frz = 1'b0, flt = 1'b1, rd_d = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [5:0] wave = 6'h00, zero = 6'h00, cout, cclk, cen;
    logic irq, ca, cb, csa, csb, oe, pin;
    logic [7:0] expq[$];
    logic [7:0] ra[5] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h04};
    logic [7:0] rm[5] = '{8'h77, 8'hff, 8'hff, 8'h3f, 8'h04};
    int err_total = 0, n_checks = 0, seed = 32'h39df_9857;
    int na = 0, nb = 0, nsa = 0, nsb = 0, n0 = 0, n2 = 0;
    always #20 clk = ~clk;
    pwmsd_top dut (.i_sys_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_freeze(frz), .o_irq(irq), .i_ch_wave(wave), .i_cnt_zero(zero), .o_ch_out(cout),
        .o_ch_clk_en(cclk), .o_ch_enable(cen), .o_clk_a_en(ca), .o_clk_b_en(cb), .o_clk_sa_en(csa),
        .o_clk_sb_en(csb), .i_fault_pin(pin), .o_ch5_pin_oe(oe));
    pwmsd_fault_src u_src (.i_level(flt), .i_oe(oe), .i_dout(cout[5]), .o_pin(pin));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    // read data stand one cycle after the strobe is taken
    always @(posedge clk) begin
        if (rd_d) chk(16'(rdata), 16'(expq.pop_front()));
        rd_d <= rd;
    end
    // counted mid-cycle, where the combinational ticks are settled
    always @(negedge clk) begin
        na += ca; nb += cb; nsa += csa; nsb += csb; n0 += cclk[0]; n2 += cclk[2];
    end
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrr
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask : rdx
    task automatic cnt(input int n);
        @(posedge clk);
        {na, nb, nsa, nsb, n0, n2} = '0;
        repeat (n) @(posedge clk);
    endtask : cnt
    task automatic pz(input logic [5:0] v);
        @(posedge clk);
        zero <= v;
        @(posedge clk);
        zero <= 6'h00;
        repeat (2) @(posedge clk);
    endtask : pz
    task automatic co(input logic [5:0] eo, input logic ei, input logic eoe);
        @(negedge clk);
        chk(16'({irq, oe, cout}), 16'({ei, eoe, eo}));
    endtask : co
    // about 4200 cycles are needed; the 30000-cycle limit means a hang
    initial begin
        #1_200_000;
        err_total++;
        end_of_test();
    end
    initial begin
        logic [7:0] d, c, s;
        logic inl, lvl;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        wave <= 6'($random(seed));
        wrr(8'h1c, 8'hff);
        rdx(8'h00, 8'h04);
        for (int i = 1; i < 8; i++) rdx(8'(4 * i), 8'h00);
        // here selects and scales change while every channel is off
        foreach (ra[i]) begin
            d = 8'($random(seed));
            wrr(ra[i], d);
            rdx(ra[i], d & rm[i]);
        end
        wrr(8'h08, 8'h00);
        wrr(8'h04, 8'h04);
        cnt(64); chk(16'(na), 16'd0);
        frz <= 1'b1;
        wrr(8'h18, 8'h3f);
        cnt(64); chk(16'(na), 16'd0);
        chk(16'(cen), 16'h003f);
        frz <= 1'b0;
        cnt(64); chk(16'(na), 16'd64);
        for (int n = 0; n < 8; n++) begin
            wrr(8'h08, 8'(n) | 8'((7 - n) << 4));
            cnt(256); chk(16'(na), 16'(256 >> n));
            chk(16'(nb), 16'(256 >> (7 - n)));
        end
        wrr(8'h08, 8'h10); wrr(8'h0c, 8'h03); wrr(8'h10, 8'h02); wrr(8'h14, 8'h00);
        cnt(240); chk(16'(nsa), 16'd40); chk(16'(nsb), 16'd30);
        chk(16'(n0), 16'd240); chk(16'(n2), 16'd120);
        wrr(8'h14, 8'h3f);
        cnt(240); chk(16'(n0), 16'd40); chk(16'(n2), 16'd30);
        wrr(8'h0c, 8'h00); repeat (100) @(posedge clk);
        cnt(1024); chk(16'(nsa), 16'd2);
        wrr(8'h0c, 8'h01); repeat (4) @(posedge clk);
        cnt(20); chk(16'(nsa), 16'd10);
        for (int k = 0; k < 4; k++) begin
            inl = k[0]; lvl = k[1];
            c = {1'b0, lvl, 1'b0, lvl, 2'b00, inl, 1'b1};
            s = {5'h00, inl, 2'b00};
            @(posedge clk) flt <= ~inl;
            wrr(8'h00, c | 8'h80); co(wave, 1'b0, 1'b0);
            @(posedge clk) flt <= inl;
            @(posedge clk); co({6{lvl}}, lvl, 1'b0);
            rdx(8'h00, c | 8'h80 | s);
            wrr(8'h00, c | 8'h20);
            flt <= ~inl;
            pz(6'h3f); co({6{lvl}}, lvl, 1'b0);
            rdx(8'h00, c | 8'h80 | (s ^ 8'h04));
            wrr(8'h00, c | 8'h80); rdx(8'h00, c | (s ^ 8'h04));
            wrr(8'h00, c | 8'h20);
            repeat (3) @(posedge clk); co({6{lvl}}, 1'b0, 1'b0);
            pz(6'h01); co({{5{lvl}}, wave[0]}, 1'b0, 1'b0);
            pz(6'h3e); co(wave, 1'b0, 1'b0);
            @(posedge clk) flt <= inl;
            @(posedge clk); co({6{lvl}}, lvl, 1'b0);
            wrr(8'h00, 8'h80); co({6{lvl}}, 1'b0, 1'b1);
            @(posedge clk); co({6{lvl}}, 1'b0, 1'b1);
            pz(6'h3f); co(wave, 1'b0, 1'b1);
        end
        end_of_test();
    end
endmodule : tb
`default_nettype wire
